// >>> logic/hpx_edge.sv
// Edge detector with a registered previous sample and combinational rise/fall, for a pin already synchronous to CLK.
// Assumes synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module hpx_edge #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic NRST,
  // Level in, edges out
  input  wire logic level,
  output logic      rise,
  output logic      fall,
  output logic      prev
);
  logic prev_q;

  // Previous sample
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      prev_q <= RST_VAL;
    end else begin
      prev_q <= level;
    end
  end

  assign prev = prev_q;
  assign rise = level && !prev_q;
  assign fall = !level && prev_q;
endmodule
`default_nettype wire

// >>> logic/hpx_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes single clock and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module hpx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             CLK,
  input  wire logic             NRST,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // Handshakes
  assign in_ready  = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_q];

  // Storage, no reset needed on data
  always_ff @(posedge CLK) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// >>> logic/hpx_host_port.sv
// Top of the host port: strap decode, pin mapping and the 6800 front end.
// Assumes all host pins are synchronous to CLK at 100 MHz.
`timescale 1ns/1ps
`default_nettype none
module hpx_host_port
  import hpx_pkg::*;
#(
  parameter int FRAME_CYCLES = FRAME_CYC,
  parameter int COLS         = 160,
  parameter int ROWS         = 160
) (
  // Clock and reset
  input  wire logic            CLK,
  input  wire logic            NRST,
  // Straps and chip reset pin
  input  wire logic [2:0]      BUS_SELECT_PINS,
  input  wire logic            HW_RESET_N,
  // Host control pins
  input  wire logic            CHIP_SELECT_N,
  input  wire logic            DATA_NOT_COMMAND,
  input  wire logic            READ_NOT_WRITE,
  input  wire logic            STROBE_E,
  // Host data pins, three-signal form
  input  wire logic [7:0]      D_IN,
  output logic      [7:0]      D_OUT,
  output logic      [7:0]      D_OE,
  // Core side: read-back values
  input  wire logic [7:0]      STATUS_BYTE,
  input  wire logic [7:0]      RDATA_BYTE,
  // Core side: write stream
  output logic                 WR_VALID,
  input  wire logic            WR_READY,
  output logic      [8:0]      WR_WORD,
  // Core side: read requests
  output logic                 RD_STATUS_REQ,
  output logic                 RD_DATA_REQ,
  output logic                 STROBE_8080_READ,
  // Mode and serial pin view
  output logic      [2:0]      MODE,
  output logic      [2:0]      SER_PINS,
  output logic                 BAD_PIN_LEVEL,
  output logic                 FIFO_FULL,
  // Display side
  input  wire logic            DISPLAY_ON,
  output logic                 TEARING_SYNC_OUT,
  output logic [COLS-1:0]      COLUMN_DRIVE_OUTPUTS,
  output logic [ROWS-1:0]      ROW_DRIVE_OE
);

  // ----------------------------------------
  // Reset and mode
  // ----------------------------------------
  logic        rst_n;
  hpx_mode_e   mode_q;
  hpx_mode_e   mode_d;

  // R16: chip initialization while hw reset low
  assign rst_n = NRST && HW_RESET_N;

  // R15: strap code decode
  always_comb begin
    unique case (BUS_SELECT_PINS)
      BS_SPI4: mode_d = HPX_M_SPI4;
      BS_SPI3: mode_d = HPX_M_SPI3;
      BS_I2C:  mode_d = HPX_M_I2C;
      BS_8080: mode_d = HPX_M_8080;
      BS_6800: mode_d = HPX_M_6800;
      default: mode_d = HPX_M_NONE;
    endcase
  end

  // R9: protocol fixed by strap levels
  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      mode_q <= HPX_M_NONE;
    end else begin
      mode_q <= mode_d;
    end
  end

  logic is_6800;
  logic is_8080;
  logic is_ser;
  assign is_6800 = (mode_q == HPX_M_6800);
  assign is_8080 = (mode_q == HPX_M_8080);
  assign is_ser  = (mode_q == HPX_M_SPI4) || (mode_q == HPX_M_SPI3) ||
                   (mode_q == HPX_M_I2C);

  // ----------------------------------------
  // Strobe edges
  // ----------------------------------------
  logic e_rise;
  logic e_fall;
  logic e_prev;

  hpx_edge #(
    .RST_VAL (1'b0)
  ) u_e_edge (
    .CLK   (CLK),
    .NRST  (rst_n),
    .level (STROBE_E),
    .rise  (e_rise),
    .fall  (e_fall),
    .prev  (e_prev)
  );

  // ----------------------------------------
  // 6800 cycle capture
  // ----------------------------------------
  logic       e_armed_q;
  logic       cap_rnw_q;
  logic       cap_dnc_q;
  logic [7:0] cap_byte_q;
  logic       cap_hit;

  // R1: cycle starts only on enable high with chip selected
  // R13: enable ignored while deselected
  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      e_armed_q <= 1'b0;
    end else if (!is_6800 || CHIP_SELECT_N) begin
      e_armed_q <= 1'b0;
    end else if (e_rise || STROBE_E) begin
      e_armed_q <= 1'b1;
    end else if (e_fall) begin
      e_armed_q <= 1'b0;
    end
  end

  // Latch only at enable fall with select held
  assign cap_hit = is_6800 && e_fall && e_armed_q && !CHIP_SELECT_N;

  // R12: byte and cycle type latched on enable fall
  // R10: read_not_write sets the cycle direction
  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      cap_rnw_q  <= 1'b0;
      cap_dnc_q  <= 1'b0;
      cap_byte_q <= BYTE_RST;
    end else if (cap_hit) begin
      cap_rnw_q  <= READ_NOT_WRITE;
      cap_dnc_q  <= DATA_NOT_COMMAND;
      cap_byte_q <= D_IN;
    end
  end

  // R14: four operations decoded
  // R11: data_not_command picks command/status or data
  hpx_op_e op;
  always_comb begin
    unique case ({READ_NOT_WRITE, DATA_NOT_COMMAND})
      2'b00: op = HPX_OP_WCMD;
      2'b10: op = HPX_OP_RSTAT;
      2'b01: op = HPX_OP_WDATA;
      2'b11: op = HPX_OP_RDATA;
    endcase
  end

  // ----------------------------------------
  // Write path through the FIFO
  // ----------------------------------------
  logic    push_valid;
  logic    push_ready;
  hpx_wr_s push_word;
  logic    fifo_out_valid;
  hpx_wr_s fifo_out_word;
  logic    wr_valid_q;
  hpx_wr_s wr_word_q;
  logic    take;

  assign push_valid        = cap_hit && !READ_NOT_WRITE;
  assign push_word.is_data = (op == HPX_OP_WDATA);
  assign push_word.byte_val = D_IN;

  hpx_fifo #(
    .WIDTH ($bits(hpx_wr_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .CLK       (CLK),
    .NRST      (rst_n),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_word),
    .out_valid (fifo_out_valid),
    .out_ready (take),
    .out_data  (fifo_out_word)
  );

  // Output stage refills when empty or being accepted
  assign take = fifo_out_valid && (!wr_valid_q || WR_READY);

  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      wr_valid_q <= 1'b0;
      wr_word_q  <= '0;
    end else if (take) begin
      wr_valid_q <= 1'b1;
      wr_word_q  <= fifo_out_word;
    end else if (WR_READY) begin
      wr_valid_q <= 1'b0;
    end
  end

  // Full flag warns host firmware; bytes past full are dropped
  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      FIFO_FULL <= 1'b0;
    end else begin
      FIFO_FULL <= !push_ready;
    end
  end

  assign WR_VALID = wr_valid_q;
  assign WR_WORD  = wr_word_q;

  // ----------------------------------------
  // Read requests and bus drive
  // ----------------------------------------
  logic       rd_drive;
  logic [7:0] rd_val;

  // Read pulses one cycle after the captured enable fall
  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      RD_STATUS_REQ <= 1'b0;
      RD_DATA_REQ   <= 1'b0;
    end else begin
      RD_STATUS_REQ <= cap_hit && (op == HPX_OP_RSTAT);
      RD_DATA_REQ   <= cap_hit && (op == HPX_OP_RDATA);
    end
  end

  // R2: 8080 read begins on strobe fall with chip selected
  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      STROBE_8080_READ <= 1'b0;
    end else begin
      STROBE_8080_READ <= is_8080 && e_fall && !CHIP_SELECT_N;
    end
  end

  // R17: drive only while selected, reading and enabled
  assign rd_drive = is_6800 && !CHIP_SELECT_N && READ_NOT_WRITE && STROBE_E;
  assign rd_val   = DATA_NOT_COMMAND ? RDATA_BYTE : STATUS_BYTE;

  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      D_OE  <= '0;
      D_OUT <= BYTE_RST;
    end else begin
      D_OE  <= {DATA_W{rd_drive}};
      D_OUT <= rd_drive ? rd_val : BYTE_RST;
    end
  end

  // ----------------------------------------
  // Serial pin mapping
  // ----------------------------------------
  hpx_ser_s ser_d;

  // R4: D0 clock, D1 data in for SPI
  // R5: D0 SCL, D1 SDA in for I2C
  always_comb begin
    ser_d.sclk   = is_ser && D_IN[0];
    ser_d.serial_data_in   = (mode_q == HPX_M_SPI4 || mode_q == HPX_M_SPI3) && D_IN[1];
    ser_d.sda_in = (mode_q == HPX_M_I2C) && D_IN[1];
  end

  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      SER_PINS <= '0;
    end else begin
      SER_PINS <= ser_d;
    end
  end

  // R3: strobe must sit at ground in serial modes
  // R6: unused data pins expected low
  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      BAD_PIN_LEVEL <= 1'b0;
    end else begin
      BAD_PIN_LEVEL <= is_ser && (STROBE_E || (D_IN[7:3] != 5'h00));
    end
  end

  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      MODE <= BS_SPI4;
    end else begin
      MODE <= BUS_SELECT_PINS;
    end
  end

  // ----------------------------------------
  // Frame sync and panel drive state
  // ----------------------------------------
  logic [$clog2(FRAME_CYCLES+1)-1:0] frame_q;

  // R7: tearing sync pulse at frame start
  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      frame_q          <= '0;
      TEARING_SYNC_OUT <= 1'b0;
    end else begin
      frame_q <= (frame_q == $bits(frame_q)'(FRAME_CYCLES-1)) ? '0 : frame_q + 1'b1;
      TEARING_SYNC_OUT <= (frame_q < $bits(frame_q)'(SYNC_CYC));
    end
  end

  // R8: display off grounds columns, floats rows
  always_ff @(posedge CLK) begin
    if (!rst_n) begin
      COLUMN_DRIVE_OUTPUTS <= '0;
      ROW_DRIVE_OE         <= '0;
    end else if (!DISPLAY_ON) begin
      COLUMN_DRIVE_OUTPUTS <= '0;
      ROW_DRIVE_OE         <= '0;
    end else begin
      COLUMN_DRIVE_OUTPUTS <= {COLS{TEARING_SYNC_OUT}};
      ROW_DRIVE_OE         <= '1;
    end
  end

endmodule
`default_nettype wire

// >>> logic/hpx_pkg.sv
// Package for the host port mode selector and 6800 parallel front end.
// Assumes one 100 MHz clock; all host pins arrive synchronous to it.
//
// Contract
// R1: In 6800 mode the shared strobe is an active-high enable and cycles start only while it is high with chip select low.
// R2: In 8080 mode the shared strobe is an active-low read strobe that starts a read when it falls with chip select low.
// R3: In serial and I2C modes the host holds the shared strobe pin at ground.
// R4: In SPI modes D0 is the serial clock and the host ties D1 and D2 together as serial data in.
// R5: In I2C mode D0 is SCL, D1 is SDA in and D2 is SDA out, with D1 and D2 tied as one SDA line. The port has no SDA out; D_OE drives only in 6800 reads.
// R6: The host should tie low any data pins the selected mode does not use.
// R7: The device drives a tearing sync output that marks frame display timing.
// R8: While the display is off, row drives float and column drives sit at ground.
// R9: The bus protocol is fixed by the bus select straps over 8 data and 5 control pins.
// R10: In 6800 mode read_not_write low is a write and high is a read, set before the enable.
// R11: data_not_command low targets command or status, high targets display data.
// R12: In 6800 mode the byte and cycle type are captured on the enable falling edge.
// R13: The enable is ignored unless chip select is low.
// R14: An enable fall with chip selected decodes write command, read status, write data or read data.
// R15: Bus select codes are 000 4-wire SPI, 001 3-wire SPI, 010 I2C, 110 8080, 100 6800.
// R16: The whole port initializes while hw_reset_n is low and runs only while it is high.
// R17: In a 6800 read the device drives D only while selected, reading and enabled.
package hpx_pkg;

  // ----------------------------------------
  // Strap codes
  // ----------------------------------------
  localparam logic [2:0] BS_SPI4 = 3'h0;
  localparam logic [2:0] BS_SPI3 = 3'h1;
  localparam logic [2:0] BS_I2C  = 3'h2;
  localparam logic [2:0] BS_8080 = 3'h6;
  localparam logic [2:0] BS_6800 = 3'h4;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int          DATA_W      = 8;
  localparam int          FIFO_DEPTH  = 16;
  localparam int          FRAME_CYC   = 1666;
  localparam int          SYNC_CYC    = 16;
  localparam logic [7:0]  BYTE_RST    = 8'h00;

  typedef enum logic [2:0] {
    HPX_M_SPI4,
    HPX_M_SPI3,
    HPX_M_I2C,
    HPX_M_8080,
    HPX_M_6800,
    HPX_M_NONE
  } hpx_mode_e;

  typedef enum logic [1:0] {
    HPX_OP_WCMD,
    HPX_OP_RSTAT,
    HPX_OP_WDATA,
    HPX_OP_RDATA
  } hpx_op_e;

  // One captured host write
  typedef struct packed {
    logic       is_data;
    logic [7:0] byte_val;
  } hpx_wr_s;

  // Serial pin view handed to the serial engines
  typedef struct packed {
    logic sclk;
    logic serial_data_in;
    logic sda_in;
  } hpx_ser_s;

endpackage

// >>> test/hpx_host_model.sv
// Host microcontroller model for the host port pins.
// Assumes the bench resolves the data bus from both drivers.
`timescale 1ns/1ps
`default_nettype none
module hpx_host_model (
  // Clock and resolved bus
  input  wire logic       CLK,
  input  wire logic [7:0] dbus,
  // Host pins
  output logic            cs_n,
  output logic            dnc,
  output logic            rnw,
  output logic            e,
  output logic [7:0]      d
);
  // Idle pins at time zero
  initial begin
    cs_n = 1'b1;
    dnc  = 1'b0;
    rnw  = 1'b0;
    e    = 1'b0;
    d    = 8'h00;
  end

  // type and select set before the strobe
  task automatic cyc(input logic sel_n, input logic rd, input logic dc,
                     input logic [7:0] wb, output logic [7:0] rb);
    @(posedge CLK);
    cs_n <= sel_n;
    rnw  <= rd;
    dnc  <= dc;
    // Released bus shows the inverse so a stale value never matches
    d    <= rd ? ~d : wb;
    @(posedge CLK);
    e <= 1'b1;
    @(posedge CLK);
    e <= 1'b0;
    @(posedge CLK);
    rb = dbus;
    cs_n <= 1'b1;
  endtask

  // strobe low, data pins tied, unused pins low
  task automatic ser_bit(input logic b);
    @(posedge CLK);
    cs_n <= 1'b0;
    e    <= 1'b0;
    rnw  <= 1'b0;
    d    <= {5'h00, b, b, 1'b0};
    @(posedge CLK);
    d <= {5'h00, b, b, 1'b1};
  endtask
endmodule
`default_nettype wire

// >>> test/hpx_host_port_monitor.sv
// Checker for the host port top: 6800 takes, read drive, display pins.
// Assumes it is bound to hpx_host_port with the same parameter values.
`timescale 1ns/1ps
`default_nettype none
module hpx_host_port_monitor
  import hpx_pkg::*;
#(
  parameter int FRAME_CYCLES = FRAME_CYC,
  parameter int COLS         = 160,
  parameter int ROWS         = 160
) (
  // Clock and resets
  input wire logic            CLK,
  input wire logic            NRST,
  input wire logic            HW_RESET_N,
  // Host pins
  input wire logic            CHIP_SELECT_N,
  input wire logic            DATA_NOT_COMMAND,
  input wire logic            READ_NOT_WRITE,
  input wire logic            STROBE_E,
  input wire logic [7:0]      D_OE,
  // Core and display side
  input wire logic            RD_STATUS_REQ,
  input wire logic            RD_DATA_REQ,
  input wire logic            STROBE_8080_READ,
  input wire logic [2:0]      MODE,
  input wire logic            DISPLAY_ON,
  input wire logic            TEARING_SYNC_OUT,
  input wire logic [COLS-1:0] COLUMN_DRIVE_OUTPUTS,
  input wire logic [ROWS-1:0] ROW_DRIVE_OE
);
  logic       run;
  logic       run_q;
  logic       e_q;
  logic       csn_q;
  logic       rnw_q;
  logic       t_q;
  logic       seen_q;
  logic [2:0] mode_q;
  int         per_q;
  logic       take;
  logic       drv;
  logic       fall8080;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!run);

  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  // Pin history; run_q masks edges that still see reset values
  always_ff @(posedge CLK) begin
    e_q    <= STROBE_E;
    csn_q  <= CHIP_SELECT_N;
    rnw_q  <= READ_NOT_WRITE;
    mode_q <= MODE;
    run_q  <= run;
    t_q    <= TEARING_SYNC_OUT;
  end
  // Cycles since last sync rise, trusted only after one rise
  always_ff @(posedge CLK) begin
    if (!run) begin
      per_q  <= 0;
      seen_q <= 1'b0;
    end else if (TEARING_SYNC_OUT && !t_q) begin
      per_q  <= 1;
      seen_q <= 1'b1;
    end else begin
      per_q <= per_q + 1;
    end
  end
  // Selected strobe falls and the read drive window
  assign run      = NRST & HW_RESET_N;
  assign take     = run_q & e_q & ~STROBE_E & ~csn_q & ~CHIP_SELECT_N & (MODE == BS_6800);
  assign fall8080 = run_q & e_q & ~STROBE_E & ~csn_q & ~CHIP_SELECT_N & (MODE == BS_8080);
  assign drv      = run_q & e_q & ~csn_q & rnw_q & (mode_q == BS_6800);

  sequence sync_s;
    TEARING_SYNC_OUT [*8] ##1 TEARING_SYNC_OUT [*8] ##1 !TEARING_SYNC_OUT;
  endsequence
  sequence rd_take_s;
    take && READ_NOT_WRITE;
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  rd_data_req_a: assert property (rd_take_s ##0 DATA_NOT_COMMAND |=> RD_DATA_REQ)
    else $error("read data take gave no request");
  rd_stat_req_a: assert property (rd_take_s ##0 !DATA_NOT_COMMAND |=> RD_STATUS_REQ)
    else $error("read status take gave no request");
  no_take_quiet_a: assert property (!take |=> !RD_DATA_REQ && !RD_STATUS_REQ)
    else $error("read request without a selected fall");
  read_drive_a: assert property (drv |-> D_OE == 8'hFF)
    else $error("data bus not driven in read window");
  bus_release_a: assert property (!drv |-> D_OE == 8'h00)
    else $error("data bus driven outside read window");
  strobe_8080_a: assert property (fall8080 |=> STROBE_8080_READ)
    else $error("8080 read strobe missed");
  display_off_a: assert property (run_q && !$past(DISPLAY_ON) |-> ROW_DRIVE_OE == '0 && COLUMN_DRIVE_OUTPUTS == '0)
    else $error("drive pins active while display off");
  sync_width_a: assert property ($rose(TEARING_SYNC_OUT) |-> sync_s)
    else $error("sync pulse width wrong");
  sync_period_a: assert property ($rose(TEARING_SYNC_OUT) && seen_q |-> per_q == FRAME_CYCLES)
    else $error("sync period wrong");
endmodule

bind hpx_host_port hpx_host_port_monitor #(
  .FRAME_CYCLES(FRAME_CYCLES),
  .COLS(COLS),
  .ROWS(ROWS)
) mon (
  .CLK(CLK), .NRST(NRST), .HW_RESET_N(HW_RESET_N), .CHIP_SELECT_N(CHIP_SELECT_N),
  .DATA_NOT_COMMAND(DATA_NOT_COMMAND), .READ_NOT_WRITE(READ_NOT_WRITE),
  .STROBE_E(STROBE_E), .D_OE(D_OE), .RD_STATUS_REQ(RD_STATUS_REQ),
  .RD_DATA_REQ(RD_DATA_REQ), .STROBE_8080_READ(STROBE_8080_READ), .MODE(MODE),
  .DISPLAY_ON(DISPLAY_ON), .TEARING_SYNC_OUT(TEARING_SYNC_OUT),
  .COLUMN_DRIVE_OUTPUTS(COLUMN_DRIVE_OUTPUTS), .ROW_DRIVE_OE(ROW_DRIVE_OE)
);
`default_nettype wire

// >>> test/hpx_host_port_tb.sv
// Bench for the host port: straps, 6800 cycles, FIFO and display pins.
// Assumes the host model drives the pins and the bench plays the core.
`timescale 1ns/1ps
`default_nettype none
module hpx_host_port_tb;
  import hpx_pkg::*;
  localparam int FRAME = 32;
  logic clk, nrst, hw_rst_n, wr_ready, display_on, cs_n, dnc, rnw, e;
  logic wr_valid, rd_stat, rd_data, rd8080, bad_pin, fifo_full, sync;
  logic [2:0] straps, mode, ser_pins;
  logic [7:0] status_b, rdata_b, d_in, d_out, d_oe, host_d;
  logic [8:0] wr_word;
  logic [159:0] cols, rows_oe;
  int errors, cmp_count, cycles;

  // Bus level from both drivers
  assign d_in = (d_oe & d_out) | (~d_oe & host_d);

  hpx_host_port #(.FRAME_CYCLES(FRAME)) dut (
    .CLK(clk), .NRST(nrst), .BUS_SELECT_PINS(straps), .HW_RESET_N(hw_rst_n),
    .CHIP_SELECT_N(cs_n), .DATA_NOT_COMMAND(dnc), .READ_NOT_WRITE(rnw), .STROBE_E(e),
    .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe), .STATUS_BYTE(status_b), .RDATA_BYTE(rdata_b),
    .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_WORD(wr_word), .RD_STATUS_REQ(rd_stat),
    .RD_DATA_REQ(rd_data), .STROBE_8080_READ(rd8080), .MODE(mode), .SER_PINS(ser_pins),
    .BAD_PIN_LEVEL(bad_pin), .FIFO_FULL(fifo_full), .DISPLAY_ON(display_on),
    .TEARING_SYNC_OUT(sync), .COLUMN_DRIVE_OUTPUTS(cols), .ROW_DRIVE_OE(rows_oe));

  hpx_host_model host (.CLK(clk), .dbus(d_in), .cs_n(cs_n), .dnc(dnc), .rnw(rnw), .e(e),
    .d(host_d));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Core side takes one word; bounded wait for valid
  task automatic drain(input logic [8:0] exp);
    int n;
    n = 0;
    while (wr_valid !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(wr_word, exp);
    @(posedge clk);
    wr_ready <= 1'b1;
    @(posedge clk);
    wr_ready <= 1'b0;
    #1;
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    @(posedge clk);
    hw_rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({6'h00, mode}, 9'h000);
    @(posedge clk);
    hw_rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check({6'h00, mode}, {6'h00, BS_6800});
  endtask
  // Strap codes SPI4, SPI3, I2C and 8080; serial pins mapped, 8080 read strobed
  task automatic t_serial;
    logic [2:0] codes [4];
    logic [7:0] rb;
    codes = '{BS_SPI4, BS_SPI3, BS_I2C, BS_8080};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      straps <= codes[i];
      repeat (2) @(posedge clk);
      #1;
      check({6'h00, mode}, {6'h00, codes[i]});
      if (codes[i] == BS_8080) begin
        host.cyc(1'b0, 1'b1, 1'b0, 8'h00, rb);
        #1;
        check({8'h00, rd8080}, 9'h001);
      end else for (int b = 0; b < 2; b++) begin
        host.ser_bit(b[0]);
        @(posedge clk);
        #1;
        check({7'h00, ser_pins[2], (codes[i] == BS_I2C) ? ser_pins[0] : ser_pins[1]},
              {7'h00, 1'b1, b[0]});
        check({8'h00, bad_pin}, 9'h000);
      end
      // Strobe up and high data pins in a serial mode must be flagged
      if (codes[i] == BS_SPI4) begin
        host.cyc(1'b1, 1'b0, 1'b0, 8'hF8, rb);
        #1;
        check({8'h00, bad_pin}, 9'h001);
      end
    end
    @(posedge clk);
    straps <= BS_6800;
    repeat (2) @(posedge clk);
  endtask
  // Command then data back to back, then an unselected write
  task automatic t_write;
    logic [7:0] rb;
    host.cyc(1'b0, 1'b0, 1'b0, 8'hA5, rb);
    host.cyc(1'b0, 1'b0, 1'b1, 8'h3C, rb);
    drain(9'h0A5);
    drain(9'h13C);
    host.cyc(1'b1, 1'b0, 1'b1, 8'h77, rb);
    repeat (4) @(posedge clk);
    #1;
    check({8'h00, wr_valid}, 9'h000);
  endtask
  task automatic t_read;
    logic [7:0] rb;
    @(posedge clk);
    status_b <= 8'h5A;
    rdata_b  <= 8'hC3;
    host.cyc(1'b0, 1'b1, 1'b0, 8'h00, rb);
    check({1'b0, rb}, 9'h05A);
    #1;
    check({7'h00, rd_stat, rd_data}, 9'h002);
    host.cyc(1'b0, 1'b1, 1'b1, 8'h00, rb);
    check({1'b0, rb}, 9'h0C3);
    #1;
    check({7'h00, rd_stat, rd_data}, 9'h001);
  endtask
  // Core stalls: stage plus 16 entries fill, the 18th is dropped
  task automatic t_fifo;
    logic [7:0] rb;
    for (int i = 0; i < 18; i++) host.cyc(1'b0, 1'b0, 1'b1, 8'(8'h10 + i), rb);
    #1;
    check({8'h00, fifo_full}, 9'h001);
    for (int i = 0; i < 17; i++) drain({1'b1, 8'(8'h10 + i)});
    repeat (3) @(posedge clk);
    #1;
    check({8'h00, wr_valid}, 9'h000);
  endtask
  task automatic t_display;
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    #1;
    check({8'h00, |rows_oe | |cols}, 9'h000);
    @(posedge clk);
    display_on <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check({8'h00, &rows_oe}, 9'h001);
    repeat (FRAME) begin
      @(posedge clk);
      #1;
      if (sync === 1'b1) n++;
    end
    check(9'(n), 9'h010);
  endtask

  // ----------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run needs about 230 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      conclude;
    end
  end
  initial begin
    errors = 0;
    cmp_count = 0;
    nrst = 1'b0;
    hw_rst_n = 1'b1;
    straps = BS_6800;
    wr_ready = 1'b0;
    display_on = 1'b0;
    status_b = 8'h00;
    rdata_b = 8'h00;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_serial;
    t_write;
    t_read;
    t_fifo;
    t_display;
    conclude;
  end
endmodule
`default_nettype wire
